//--- hdl/pltm_top.sv
`timescale 1ns/1ps
`default_nettype none
module pltm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hw_standby_n,
  input wire logic [pltm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pltm_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pltm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pltm_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pulse_output_pin
);
  import pltm_pkg::*;

  // Standby pin comes from outside, so it is synchronised first
  logic standby_sync1;
  logic standby_sync2;
  logic standby;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      standby_sync1 <= 1'b0;
      standby_sync2 <= 1'b0;
    end
    else
    begin
      standby_sync1 <= ~hw_standby_n;
      standby_sync2 <= standby_sync1;
    end
  end

  assign standby = standby_sync2;

  // Write channel state
  logic aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic w_held;
  logic [DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic [ADDR_W-1:0] next_aw_addr;
  logic next_w_held;
  logic [DATA_W-1:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic wr_fire;
  logic wr_ok;
  logic [ADDR_W-1:0] wr_addr;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_addr = {aw_addr[ADDR_W-1:2], 2'b00};

  // Unknown offsets and narrow writes to 16-bit registers are refused
  always_comb
  begin
    case (wr_addr)
      OFS_RUN, OFS_CTRL, OFS_MODE, OFS_PINACT:
        wr_ok = w_strb[0];
      OFS_CNT4, OFS_CNT5:
        wr_ok = (w_strb[1:0] == STRB_HALF);
      OFS_CMPA4, OFS_CMPB4, OFS_BUFC4, OFS_BUFD4:
        wr_ok = (w_strb[1:0] == STRB_HALF);
      default:
        wr_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // Software registers
  logic [RUN_W-1:0] run_bits;
  logic [2:0] ctrl;
  logic [1:0] mode_code;
  logic [1:0] pin_act;
  logic [CNT_W-1:0] cmp_a;
  logic [CNT_W-1:0] cmp_b;
  logic [CNT_W-1:0] buf_c;
  logic [CNT_W-1:0] buf_d;
  logic [RUN_W-1:0] next_run_bits;
  logic [2:0] next_ctrl;
  logic [1:0] next_mode_code;
  logic [1:0] next_pin_act;
  logic [CNT_W-1:0] next_cmp_a;
  logic [CNT_W-1:0] next_cmp_b;
  logic [CNT_W-1:0] next_buf_c;
  logic [CNT_W-1:0] next_buf_d;
  logic do_write;
  logic load_cnt4;
  logic load_cnt5;
  logic match_a;
  logic match_b;
  logic [CNT_W-1:0] cnt4;
  logic [CNT_W-1:0] cnt5;
  pltm_mode_t mode;

  assign do_write = wr_fire && wr_ok;
  assign load_cnt4 = do_write && (wr_addr == OFS_CNT4);
  assign load_cnt5 = do_write && (wr_addr == OFS_CNT5);

  always_comb
  begin
    case (mode_code)
      MODE_CODE_PWM1:
        mode = PLTM_PWM1;
      MODE_CODE_PWM2:
        mode = PLTM_PWM2;
      default:
        mode = PLTM_NORMAL;
    endcase
  end

  always_comb
  begin
    next_run_bits = run_bits;
    next_ctrl = ctrl;
    next_mode_code = mode_code;
    next_pin_act = pin_act;
    next_cmp_a = cmp_a;
    next_cmp_b = cmp_b;
    next_buf_c = buf_c;
    next_buf_d = buf_d;
    // Buffered values move in at the clear so one period never mixes
    if (pin_act[PIN_BUFFER] && match_b && mode != PLTM_NORMAL)
    begin
      next_cmp_a = buf_c;
      next_cmp_b = buf_d;
    end
    if (do_write)
    begin
      case (wr_addr)
        OFS_RUN:
          next_run_bits = w_data[RUN_W-1:0];
        OFS_CTRL:
          next_ctrl = w_data[2:0];
        OFS_MODE:
          next_mode_code = w_data[1:0];
        OFS_PINACT:
          next_pin_act = w_data[1:0];
        OFS_CMPA4:
          next_cmp_a = w_data[CNT_W-1:0];
        OFS_CMPB4:
          next_cmp_b = w_data[CNT_W-1:0];
        OFS_BUFC4:
          next_buf_c = w_data[CNT_W-1:0];
        OFS_BUFD4:
          next_buf_d = w_data[CNT_W-1:0];
        default:
          next_run_bits = run_bits;
      endcase
    end
    if (standby)
      next_run_bits = RUN_RESET;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_bits <= RUN_RESET;
      ctrl <= CTRL_RESET;
      mode_code <= MODE_RESET;
      pin_act <= PINACT_RESET;
      cmp_a <= CMP_RESET;
      cmp_b <= CMP_RESET;
      buf_c <= CMP_RESET;
      buf_d <= CMP_RESET;
    end
    else
    begin
      run_bits <= next_run_bits;
      ctrl <= next_ctrl;
      mode_code <= next_mode_code;
      pin_act <= next_pin_act;
      cmp_a <= next_cmp_a;
      cmp_b <= next_cmp_b;
      buf_c <= next_buf_c;
      buf_d <= next_buf_d;
    end
  end

  // Count clock prescaler, shared by both channels
  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] next_pre;
  logic pre_tick;

  always_comb
  begin
    next_pre = pre + 6'h01;
    case (ctrl[CTRL_PRE_HI:CTRL_PRE_LO])
      PRE_DIV1:
        pre_tick = 1'b1;
      PRE_DIV4:
        pre_tick = ((pre & PRE_MASK4) == PRE_MASK4);
      PRE_DIV16:
        pre_tick = ((pre & PRE_MASK16) == PRE_MASK16);
      default:
        pre_tick = (pre == PRE_MASK64);
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre <= '0;
    else
      pre <= next_pre;
  end

  // Channel five is the low half, channel four the high half
  logic carry5;
  logic tick4;

  assign tick4 = ctrl[CTRL_CASCADE] ? carry5 : pre_tick;
  // Matches act when the high half leaves the value, so each compare
  // value spans a full low-half wrap and the period is B plus one wraps
  assign match_a = run_bits[RUN_CH4] && tick4 && (cnt4 == cmp_a);
  assign match_b = run_bits[RUN_CH4] && tick4 && (cnt4 == cmp_b);

  pltm_channel_counter u_cnt5 (
    .aclk(aclk),
    .aresetn(aresetn),
    .standby(standby),
    .run(run_bits[RUN_CH5]),
    .tick(pre_tick),
    .clear(1'b0),
    .load(load_cnt5),
    .load_value(w_data[CNT_W-1:0]),
    .count(cnt5),
    .carry(carry5)
  );

  pltm_channel_counter u_cnt4 (
    .aclk(aclk),
    .aresetn(aresetn),
    .standby(standby),
    .run(run_bits[RUN_CH4]),
    .tick(tick4),
    .clear(match_b && mode != PLTM_NORMAL),
    .load(load_cnt4),
    .load_value(w_data[CNT_W-1:0]),
    .count(cnt4),
    .carry()
  );

  pltm_pin_stage u_pin (
    .aclk(aclk),
    .aresetn(aresetn),
    .standby(standby),
    .run(run_bits[RUN_CH4]),
    .mode(mode),
    .init_level(pin_act[PIN_INIT]),
    .match_a(match_a),
    .match_b(match_b),
    .pin(pulse_output_pin)
  );

  // Read channel: one read at a time, answered on the next edge
  logic [DATA_W-1:0] rd_word;
  logic rd_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic next_arready;
  logic next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0] next_rresp;

  assign rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  always_comb
  begin
    rd_word = '0;
    rd_ok = 1'b1;
    case (rd_addr)
      OFS_RUN:
        rd_word[RUN_W-1:0] = run_bits;
      OFS_CTRL:
        rd_word[2:0] = ctrl;
      OFS_MODE:
        rd_word[1:0] = mode_code;
      OFS_PINACT:
        rd_word[1:0] = pin_act;
      OFS_CNT4:
        rd_word[CNT_W-1:0] = cnt4;
      OFS_CNT5:
        rd_word[CNT_W-1:0] = cnt5;
      OFS_CMPA4:
        rd_word[CNT_W-1:0] = cmp_a;
      OFS_CMPB4:
        rd_word[CNT_W-1:0] = cmp_b;
      OFS_BUFC4:
        rd_word[CNT_W-1:0] = buf_c;
      OFS_BUFD4:
        rd_word[CNT_W-1:0] = buf_d;
      OFS_STATUS:
      begin
        rd_word[STAT_PIN] = pulse_output_pin;
        rd_word[STAT_STANDBY] = standby;
      end
      default:
        rd_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule : pltm_top
`default_nettype wire

//--- hdl/pltm_pkg.sv
package pltm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int RUN_W = 6;
  localparam int PRE_W = 6;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [CNT_W-1:0] CMP_RESET = 16'hffff;

  localparam logic [ADDR_W-1:0] OFS_RUN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PINACT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CNT4 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CNT5 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CMPA4 = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CMPB4 = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_BUFC4 = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_BUFD4 = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h28;

  localparam int RUN_CH4 = 4;
  localparam int RUN_CH5 = 5;
  localparam int CTRL_CASCADE = 0;
  localparam int CTRL_PRE_LO = 1;
  localparam int CTRL_PRE_HI = 2;
  localparam int PIN_INIT = 0;
  localparam int PIN_BUFFER = 1;
  localparam int STAT_PIN = 0;
  localparam int STAT_STANDBY = 1;

  localparam logic [RUN_W-1:0] RUN_RESET = 6'h00;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] PINACT_RESET = 2'h0;

  localparam logic [1:0] MODE_CODE_PWM1 = 2'h1;
  localparam logic [1:0] MODE_CODE_PWM2 = 2'h2;

  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_DIV16 = 2'h2;
  localparam logic [PRE_W-1:0] PRE_MASK4 = 6'h03;
  localparam logic [PRE_W-1:0] PRE_MASK16 = 6'h0f;
  localparam logic [PRE_W-1:0] PRE_MASK64 = 6'h3f;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] STRB_HALF = 2'h3;

  typedef enum logic [1:0] {
    PLTM_NORMAL,
    PLTM_PWM1,
    PLTM_PWM2
  } pltm_mode_t;
endpackage : pltm_pkg

//--- hdl/pltm_channel_counter.sv
`timescale 1ns/1ps
`default_nettype none
module pltm_channel_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby,
  input wire logic run,
  input wire logic tick,
  input wire logic clear,
  input wire logic load,
  input wire logic [pltm_pkg::CNT_W-1:0] load_value,
  output logic [pltm_pkg::CNT_W-1:0] count,
  output logic carry
);
  import pltm_pkg::*;

  logic [CNT_W-1:0] next_count;

  // Software load wins so a written value is never lost to counting
  always_comb
  begin
    next_count = count;
    carry = 1'b0;
    if (standby)
      next_count = CNT_RESET;
    else if (load)
      next_count = load_value;
    else if (run && tick)
    begin
      carry = (count == CNT_MAX);
      if (clear)
        next_count = CNT_RESET;
      else
        next_count = count + 16'h0001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= CNT_RESET;
    else
      count <= next_count;
  end
endmodule : pltm_channel_counter
`default_nettype wire

//--- hdl/pltm_pin_stage.sv
`timescale 1ns/1ps
`default_nettype none
module pltm_pin_stage (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby,
  input wire logic run,
  input wire pltm_pkg::pltm_mode_t mode,
  input wire logic init_level,
  input wire logic match_a,
  input wire logic match_b,
  output logic pin
);
  import pltm_pkg::*;

  logic next_pin;

  always_comb
  begin
    next_pin = pin;
    if (standby || !run)
      next_pin = init_level;
    else
    begin
      case (mode)
        PLTM_PWM1:
        begin
          // Clear beats set when both compare values are equal
          if (match_b)
            next_pin = 1'b0;
          else if (match_a)
            next_pin = 1'b1;
        end
        PLTM_PWM2:
        begin
          if (match_b)
            next_pin = init_level;
          else if (match_a)
            next_pin = ~init_level;
        end
        default:
          next_pin = init_level;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin <= 1'b0;
    else
      pin <= next_pin;
  end
endmodule : pltm_pin_stage
`default_nettype wire

//--- dv/pltm_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pltm_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pltm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pltm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [pltm_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pltm_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both halves offered together, so one edge takes both
  logic wr_take;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before bready");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before rready");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_release_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released");
  write_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not dropped");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[ADDR_W-1:2] > OFS_STATUS[ADDR_W-1:2]
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  half_write_a: assert property (wr_take && s_axi_wstrb[1:0] != STRB_HALF
    && s_axi_awaddr inside {[OFS_CNT4:OFS_BUFD4]}
    |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("narrow write to 16-bit register accepted");
  full_write_a: assert property (wr_take && s_axi_wstrb[1:0] == STRB_HALF
    && s_axi_awaddr inside {[OFS_CNT4:OFS_BUFD4]} && s_axi_awaddr[1:0] == 2'h0
    |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("full write to 16-bit register refused");
endmodule : pltm_top_asserts
bind pltm_top pltm_top_asserts i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire

//--- dv/pltm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pltm_top_tb;
  import pltm_pkg::*;
  localparam int LIMIT = 20000;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic hw_standby_n = 1'h1;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, pin;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] map_a [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
    8'h18, 8'h1c, 8'h20, 8'h24};
  logic [31:0] map_v [10] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0,
    32'hffff, 32'hffff, 32'hffff, 32'hffff};

  pltm_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .hw_standby_n(hw_standby_n),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pulse_output_pin(pin));

  always #10 aclk = ~aclk;

  task conclude;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      conclude();
    end
  end

  task check_word(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  // Ready is held up from the request on, so the answer is taken at once
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
      if (bvalid && bready)
      begin
        check_word("write response", {30'h0, er}, {30'h0, bresp});
        bready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'h0;
      if (rvalid && rready)
      begin
        check_word("read data", ed, rdata);
        check_word("read response", {30'h0, er}, {30'h0, rresp});
        rready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask : rd

  task wait_pin(input logic lvl, input int lim);
    int n;
    n = 0;
    while (pin !== lvl && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    check_word("pulse pin", {31'h0, lvl}, {31'h0, pin});
  endtask : wait_pin

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    check_word("pin at reset", 32'h0, {31'h0, pin});
    for (int i = 0; i < 10; i++)
      rd(map_a[i], map_v[i], RESP_OKAY);
    rd(8'h2c, 32'h0, RESP_SLVERR);
    wr(8'h30, 32'h1, 4'hf, RESP_SLVERR);
    wr(OFS_CMPA4, 32'h1234, 4'h1, RESP_SLVERR);
    wr(OFS_CNT4, 32'h1234, 4'h2, RESP_SLVERR);
    rd(OFS_CMPA4, 32'hffff, RESP_OKAY);
    rd(OFS_CNT4, 32'h0, RESP_OKAY);
    wr(OFS_RUN, 32'h3f, 4'hf, RESP_OKAY);
    rd(OFS_RUN, 32'h3f, RESP_OKAY);
    wr(OFS_RUN, 32'h0, 4'hf, RESP_OKAY);
    for (int m = 0; m < 3; m++)
    begin
      wr(OFS_MODE, m, 4'hf, RESP_OKAY);
      rd(OFS_MODE, m, RESP_OKAY);
    end
    // Preloading the low half keeps each wrap within a few dozen cycles
    wr(OFS_MODE, {30'h0, MODE_CODE_PWM1}, 4'hf, RESP_OKAY);
    wr(OFS_PINACT, 32'h2, 4'hf, RESP_OKAY);
    wr(OFS_CMPA4, 32'h0, 4'h3, RESP_OKAY);
    wr(OFS_CMPB4, 32'h1, 4'h3, RESP_OKAY);
    wr(OFS_BUFC4, 32'h5, 4'h3, RESP_OKAY);
    wr(OFS_BUFD4, 32'h6, 4'h3, RESP_OKAY);
    wr(OFS_CNT5, 32'hffc0, 4'h3, RESP_OKAY);
    wr(OFS_RUN, 32'h30, 4'hf, RESP_OKAY);
    wait_pin(1'h1, 300);
    rd(OFS_CNT4, 32'h1, RESP_OKAY);
    wr(OFS_CNT5, 32'hffc0, 4'h3, RESP_OKAY);
    wait_pin(1'h0, 300);
    rd(OFS_CNT4, 32'h0, RESP_OKAY);
    rd(OFS_CMPA4, 32'h5, RESP_OKAY);
    rd(OFS_CMPB4, 32'h6, RESP_OKAY);
    wr(OFS_RUN, 32'h0, 4'hf, RESP_OKAY);
    wr(OFS_PINACT, 32'h1, 4'hf, RESP_OKAY);
    wait_pin(1'h1, 10);
    rd(OFS_STATUS, 32'h1, RESP_OKAY);
    wr(OFS_CNT4, 32'h3, 4'h3, RESP_OKAY);
    wr(OFS_RUN, 32'h30, 4'hf, RESP_OKAY);
    @(posedge aclk);
    hw_standby_n <= 1'h0;
    repeat (6) @(posedge aclk);
    hw_standby_n <= 1'h1;
    repeat (4) @(posedge aclk);
    rd(OFS_CNT4, 32'h0, RESP_OKAY);
    rd(OFS_CNT5, 32'h0, RESP_OKAY);
    rd(OFS_RUN, 32'h0, RESP_OKAY);
    wait_pin(1'h1, 10);
    // Second pwm mode: A flips away from the initial level, B restores it
    wr(OFS_MODE, {30'h0, MODE_CODE_PWM2}, 4'hf, RESP_OKAY);
    wr(OFS_CMPA4, 32'h0, 4'h3, RESP_OKAY);
    wr(OFS_CMPB4, 32'h1, 4'h3, RESP_OKAY);
    wr(OFS_CNT5, 32'hffc0, 4'h3, RESP_OKAY);
    wr(OFS_RUN, 32'h30, 4'hf, RESP_OKAY);
    wait_pin(1'h0, 300);
    wr(OFS_CNT5, 32'hffc0, 4'h3, RESP_OKAY);
    wait_pin(1'h1, 300);
    rd(OFS_CNT4, 32'h0, RESP_OKAY);
    conclude();
  end
endmodule : pltm_top_tb
`default_nettype wire
